// ---- logic/pld_ctrl.v ----
// Power-loss controlled deceleration and run/trip sequencing for a motor drive.
// Assumes bus voltage and settings come from logic on i_clk; discrete
// commands and power status come from pins and are synchronised here.
`include "pld_defines.vh"

module pld_ctrl #(
    parameter [31:0] TICK_CYC = `PLD_TICK_CYC
) (
    input  wire                 i_clk,                    // 200 MHz clock
    input  wire                 i_resetn,                 // Async reset, active low
    input  wire [1:0]           i_pl_decel_enable,        // Feature enable code
    input  wire [`PLD_VW-1:0]   i_bus_trigger_level,      // Trigger level, 0.1 V
    input  wire [`PLD_VW-1:0]   i_bus_overvolt_threshold, // Pause threshold, 0.1 V
    input  wire [`PLD_TW-1:0]   i_pl_decel_time,          // Decel time, 0.01 s
    input  wire [`PLD_FW-1:0]   i_pl_initial_freq_drop,   // Initial drop, 0.01 Hz
    input  wire [`PLD_FW-1:0]   i_max_freq,               // Ramp span, 0.01 Hz
    input  wire [`PLD_FW-1:0]   i_freq_target,            // Normal speed, 0.01 Hz
    input  wire [`PLD_VW-1:0]   i_bus_voltage,            // Measured bus, 0.1 V
    input  wire                 i_stop_key_enable,        // Stop key function on
    input  wire                 i_retry_mode,             // Auto restart after trip
    input  wire                 i_run_cmd,                // Run command pin
    input  wire                 i_alarm_reset,            // Alarm reset pin
    input  wire                 i_stop_key,               // Stop key pin
    input  wire                 i_input_power_ok,         // Mains present pin
    input  wire                 i_trip,                   // Fault trip pin
    input  wire                 i_undervolt,              // Bus under-voltage pin
    output reg  [`PLD_FW-1:0]   o_freq_cmd,               // Frequency to modulator
    output wire                 o_output_on,              // Modulator gates enabled
    output wire                 o_pl_decel_active,        // Power-loss decel running
    output wire                 o_pl_hold,                // Decel paused by bus
    output reg                  o_trip_alarm,             // Trip alarm latched
    output wire [2:0]           o_state                   // Controller state
);

    // Pin synchronisers: a change counts once stages two and three agree
    wire [`PLD_PIN_N-1:0] pins_raw = {i_undervolt, i_trip, i_input_power_ok,
                                      i_stop_key, i_alarm_reset, i_run_cmd};
    reg  [`PLD_PIN_N-1:0] pin_s1;
    reg  [`PLD_PIN_N-1:0] pin_s2;
    reg  [`PLD_PIN_N-1:0] pin_s3;
    reg  [`PLD_PIN_N-1:0] pin_q;
    reg  [`PLD_PIN_N-1:0] pin_qd;

    genvar g;
    generate
        for (g = 0; g < `PLD_PIN_N; g = g + 1) begin : g_sync
            always @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    pin_s1[g] <= 1'b0;
                    pin_s2[g] <= 1'b0;
                    pin_s3[g] <= 1'b0;
                    pin_q[g]  <= 1'b0;
                    pin_qd[g] <= 1'b0;
                end else begin
                    pin_s1[g] <= pins_raw[g];
                    pin_s2[g] <= pin_s1[g];
                    pin_s3[g] <= pin_s2[g];
                    if (pin_s2[g] == pin_s3[g]) begin
                        pin_q[g] <= pin_s3[g];
                    end
                    pin_qd[g] <= pin_q[g];
                end
            end
        end
    endgenerate

    wire run_cmd   = pin_q[`PLD_PIN_RUN];
    wire arst_rise = pin_q[`PLD_PIN_ARST] & ~pin_qd[`PLD_PIN_ARST];
    wire stop_rise = pin_q[`PLD_PIN_STOP] & ~pin_qd[`PLD_PIN_STOP];
    wire power_ok  = pin_q[`PLD_PIN_PWR];
    wire trip_in   = pin_q[`PLD_PIN_TRIP];
    wire uv_in     = pin_q[`PLD_PIN_UV];

    // Settings decode; code 00 and any undefined code mean off
    wire feat_on   = (i_pl_decel_enable == `PLD_EN_ENABLE);
    wire at_trig   = (i_bus_voltage <= i_bus_trigger_level);
    wire over_volt = (i_bus_voltage > i_bus_overvolt_threshold);
    wire stop_ok   = stop_rise & i_stop_key_enable;
    wire [`PLD_TW-1:0] time_eff = (i_pl_decel_time < `PLD_TIME_MIN) ?
                                  `PLD_TIME_MIN : i_pl_decel_time;

    // State codes shared with the checker through the defines header
    localparam [2:0] ST_IDLE  = `PLD_ST_IDLE;
    localparam [2:0] ST_RUN   = `PLD_ST_RUN;
    localparam [2:0] ST_STEP  = `PLD_ST_STEP;
    localparam [2:0] ST_RAMP  = `PLD_ST_RAMP;
    localparam [2:0] ST_HOLD  = `PLD_ST_HOLD;
    localparam [2:0] ST_TRIP  = `PLD_ST_TRIP;
    localparam [2:0] ST_COAST = `PLD_ST_COAST;

    reg  [2:0]          state;
    reg  [2:0]          next_state;
    reg  [31:0]         tick_cnt;
    reg  [31:0]         acc;
    reg                 stop_latch;

    wire tick      = (tick_cnt == TICK_CYC - 32'h1);
    wire in_decel  = (state == ST_STEP) || (state == ST_RAMP) ||
                     (state == ST_HOLD);

    // Stop key holds the drive stopped until the run command is released
    wire run_allow = run_cmd & ~stop_latch;

    // Trip outranks all in run, under-voltage in ramp and pause; mains return is ignored in decel
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (run_allow) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (trip_in) begin
                    next_state = ST_TRIP;
                end else if (feat_on && at_trig) begin
                    next_state = ST_STEP;
                end else if (!feat_on && !power_ok) begin
                    next_state = ST_COAST;
                end else if (!run_allow || stop_ok) begin
                    next_state = ST_IDLE;
                end
            end
            ST_STEP: begin
                next_state = ST_RAMP;
            end
            ST_RAMP: begin
                if (uv_in) begin
                    next_state = ST_TRIP;
                end else if (o_freq_cmd == {`PLD_FW{1'b0}}) begin
                    next_state = ST_IDLE;
                end else if (over_volt) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (uv_in) begin
                    next_state = ST_TRIP;
                end else if (!over_volt) begin
                    next_state = ST_RAMP;
                end
            end
            ST_TRIP: begin
                if (arst_rise) begin
                    next_state = run_allow ? ST_RUN : ST_IDLE;
                end else if (stop_ok) begin
                    next_state = ST_IDLE;
                end else if (i_retry_mode && !trip_in && !uv_in) begin
                    next_state = ST_RUN;
                end
            end
            ST_COAST: begin
                if (power_ok) begin
                    next_state = run_allow ? ST_RUN : ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state        <= ST_IDLE;
            o_freq_cmd   <= {`PLD_FW{1'b0}};
            o_trip_alarm <= 1'b0;
            stop_latch   <= 1'b0;
            tick_cnt     <= 32'h0;
            acc          <= 32'h0;
        end else begin
            state <= next_state;

            // Stop key is ignored entirely while its function is off
            if (stop_ok) begin
                stop_latch <= 1'b1;
            end else if (!run_cmd) begin
                stop_latch <= 1'b0;
            end

            // Alarm is set on the edge into trip and held until the edge that leaves trip
            if (next_state == ST_TRIP) begin
                o_trip_alarm <= 1'b1;
            end else if (state == ST_TRIP) begin
                o_trip_alarm <= 1'b0;
            end

            // Counter idles outside decel so every decel starts on a whole tick at the step
            tick_cnt <= (tick || !in_decel) ? 32'h0 : tick_cnt + 32'h1;

            case (state)
                ST_RUN: begin
                    o_freq_cmd <= (next_state == ST_RUN) ? i_freq_target : o_freq_cmd;
                    acc        <= 32'h0;
                end
                ST_STEP: begin
                    // Saturate at zero rather than wrap on a large drop
                    o_freq_cmd <= (o_freq_cmd > i_pl_initial_freq_drop) ?
                                  o_freq_cmd - i_pl_initial_freq_drop :
                                  {`PLD_FW{1'b0}};
                end
                ST_RAMP: begin
                    // Span over time: add span per tick, spend time per step
                    if (tick) begin
                        acc <= acc + {16'h0, i_max_freq};
                    end else if (acc >= {13'h0, time_eff} &&
                                 o_freq_cmd != {`PLD_FW{1'b0}}) begin
                        acc        <= acc - {13'h0, time_eff};
                        o_freq_cmd <= o_freq_cmd - {{(`PLD_FW-1){1'b0}}, 1'b1};
                    end
                end
                ST_HOLD: begin
                    // Ticks seen in a pause are dropped, not owed later
                    o_freq_cmd <= o_freq_cmd;
                end
                default: begin
                    o_freq_cmd <= {`PLD_FW{1'b0}};
                    acc        <= 32'h0;
                end
            endcase
        end
    end

    // Output stays on through the whole power-loss ramp, mains or not
    assign o_output_on       = (state == ST_RUN) || in_decel;
    assign o_pl_decel_active = in_decel;
    assign o_pl_hold         = (state == ST_HOLD);
    assign o_state           = state;

endmodule

// ---- inc/pld_defines.vh ----
// Constants for the power-loss controlled deceleration controller.
// Assumes settings arrive as static binary words in the units noted below.
`ifndef PLD_DEFINES_VH
`define PLD_DEFINES_VH

// Enable setting codes
`define PLD_EN_DISABLE   2'h0
`define PLD_EN_ENABLE    2'h1

// Widths: voltage 0.1 V units, frequency 0.01 Hz units, time 0.01 s units
`define PLD_VW           14
`define PLD_FW           16
`define PLD_TW           19

// Upper limits of the settings and lower limit of the decel time
`define PLD_VOLT_MAX     14'h2710
`define PLD_DROP_MAX     16'h03e8
`define PLD_TIME_MIN     19'h00001
`define PLD_TIME_MAX     19'h57e40

// Time base of the deceleration time setting
`define PLD_CLK_MHZ      200
`define PLD_TICK_US      10000
`define PLD_TICK_CYC     (`PLD_TICK_US * `PLD_CLK_MHZ)

// Controller states
`define PLD_ST_IDLE      3'h0
`define PLD_ST_RUN       3'h1
`define PLD_ST_STEP      3'h2
`define PLD_ST_RAMP      3'h3
`define PLD_ST_HOLD      3'h4
`define PLD_ST_TRIP      3'h5
`define PLD_ST_COAST     3'h6

// Synchronised pin vector layout
`define PLD_PIN_N        6
`define PLD_PIN_RUN      0
`define PLD_PIN_ARST     1
`define PLD_PIN_STOP     2
`define PLD_PIN_PWR      3
`define PLD_PIN_TRIP     4
`define PLD_PIN_UV       5

`endif

// ---- test/pld_ctrl_properties.sv ----
// Checker for the power-loss deceleration controller, bound to its ports.
// Assumes the state codes and widths of pld_defines.vh.
`include "pld_defines.vh"
module pld_ctrl_props (
    input wire logic              i_clk,                    // Clock
    input wire logic              i_resetn,                 // Reset, active low
    input wire logic [1:0]        i_pl_decel_enable,        // Enable code
    input wire logic [`PLD_VW-1:0] i_bus_trigger_level,     // Trigger
    input wire logic [`PLD_VW-1:0] i_bus_overvolt_threshold, // Pause level
    input wire logic [`PLD_FW-1:0] i_pl_initial_freq_drop,  // Step size
    input wire logic [`PLD_VW-1:0] i_bus_voltage,           // Bus
    input wire logic [`PLD_FW-1:0] o_freq_cmd,              // Frequency
    input wire logic              o_output_on,              // Output on
    input wire logic              o_pl_decel_active,        // Decel
    input wire logic              o_trip_alarm,             // Alarm
    input wire logic [2:0]        o_state                   // State
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_off_no_step: assert property (
        o_state == `PLD_ST_RUN && i_pl_decel_enable != `PLD_EN_ENABLE
        |=> o_state != `PLD_ST_STEP) else $error("decel entered while off");
    chk_trig_entry: assert property (
        o_state == `PLD_ST_RUN && i_pl_decel_enable == `PLD_EN_ENABLE
        && i_bus_voltage <= i_bus_trigger_level
        |=> o_state inside {`PLD_ST_STEP, `PLD_ST_TRIP}) else $error("no decel entry");
    chk_step_drop: assert property (
        o_state == `PLD_ST_STEP |=> o_state == `PLD_ST_RAMP
        && o_freq_cmd == (($past(o_freq_cmd) > $past(i_pl_initial_freq_drop)) ?
        $past(o_freq_cmd) - $past(i_pl_initial_freq_drop) : 16'h0))
        else $error("initial drop wrong");
    chk_ramp_slope: assert property (
        o_state == `PLD_ST_RAMP ##1 o_state == `PLD_ST_RAMP
        |-> o_freq_cmd == $past(o_freq_cmd) || o_freq_cmd == $past(o_freq_cmd) - 16'h1)
        else $error("ramp not linear");
    chk_hold_entry: assert property (
        o_state == `PLD_ST_RAMP && i_bus_voltage > i_bus_overvolt_threshold
        |=> o_state inside {`PLD_ST_HOLD, `PLD_ST_TRIP, `PLD_ST_IDLE})
        else $error("no pause on high bus");
    chk_hold_freeze: assert property (
        o_state == `PLD_ST_HOLD ##1 o_state inside {`PLD_ST_HOLD, `PLD_ST_RAMP}
        |-> $stable(o_freq_cmd)) else $error("frequency moved in pause");
    chk_hold_resume: assert property (
        o_state == `PLD_ST_HOLD && i_bus_voltage <= i_bus_overvolt_threshold
        |=> o_state inside {`PLD_ST_RAMP, `PLD_ST_TRIP}) else $error("no resume");
    chk_decel_kept: assert property (
        o_pl_decel_active |=> o_pl_decel_active || o_state == `PLD_ST_TRIP
        || (o_state == `PLD_ST_IDLE && $past(o_freq_cmd) == 16'h0))
        else $error("decel left early");
    chk_coast_quiet: assert property (
        o_state == `PLD_ST_COAST ##1 o_state == `PLD_ST_COAST
        |-> !o_output_on && o_freq_cmd == 16'h0 && !o_trip_alarm)
        else $error("coast not quiet");
    chk_trip_alarm: assert property (
        o_state == `PLD_ST_TRIP |-> o_trip_alarm) else $error("trip without alarm");
    cov_hold: cover property (o_state == `PLD_ST_HOLD ##1 o_state == `PLD_ST_RAMP);
    cov_coast: cover property (o_state == `PLD_ST_COAST);
    cov_restart: cover property (o_state == `PLD_ST_TRIP ##1 o_state == `PLD_ST_RUN);
endmodule
bind pld_ctrl pld_ctrl_props pld_ctrl_props_inst (.i_clk, .i_resetn, .i_pl_decel_enable,
    .i_bus_trigger_level, .i_bus_overvolt_threshold, .i_pl_initial_freq_drop,
    .i_bus_voltage, .o_freq_cmd, .o_output_on, .o_pl_decel_active, .o_trip_alarm, .o_state);

// ---- test/pld_bus_model.sv ----
// DC bus and load model on the far side of the controller.
// Assumes mains and regen requests are driven on the same clock.
module pld_bus_model (
    input  wire logic        i_clk,   // Clock
    input  wire logic        i_resetn, // Reset, active low
    input  wire logic        i_pwr,   // Mains present
    input  wire logic        i_regen, // Load feeding energy back
    output logic      [13:0] o_bus,   // Bus voltage, 0.1 V
    output logic             o_uv     // Bus under-voltage
);
    timeunit 1ns;
    timeprecision 100ps;
    // Sag is slow so a full ramp can run before the bus collapses
    always @(posedge i_clk) begin
        if (!i_resetn) o_bus <= 14'h0bb8;
        else if (i_regen) o_bus <= o_bus + 14'h0008;
        else if (!i_pwr) o_bus <= o_bus - 14'h0001;
        else o_bus <= 14'h0bb8;
    end
    assign o_uv = o_bus < 14'h07d0;
endmodule

// ---- test/power_loss_decel_ctrl_bench.sv ----
// Bench for the power-loss deceleration controller with a bus model.
// Assumes TICK_CYC of 20 and the state codes of pld_defines.vh.
`include "pld_defines.vh"
module power_loss_decel_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk, i_resetn, i_stop_key_enable, i_retry_mode, i_run_cmd;
    logic        i_alarm_reset, i_stop_key, i_input_power_ok, i_trip, regen, i_undervolt;
    logic        o_output_on, o_pl_decel_active, o_pl_hold, o_trip_alarm;
    logic [1:0]  i_pl_decel_enable;
    logic [2:0]  o_state;
    logic [13:0] i_bus_trigger_level, i_bus_overvolt_threshold, i_bus_voltage;
    logic [18:0] i_pl_decel_time;
    logic [15:0] i_pl_initial_freq_drop, i_max_freq, i_freq_target, o_freq_cmd;
    int          n_fail = 0;
    int          n_tests = 0;
    pld_ctrl #(.TICK_CYC(32'h14)) pld_ctrl_inst (.i_clk, .i_resetn, .i_pl_decel_enable,
        .i_bus_trigger_level, .i_bus_overvolt_threshold, .i_pl_decel_time,
        .i_pl_initial_freq_drop, .i_max_freq, .i_freq_target, .i_bus_voltage,
        .i_stop_key_enable, .i_retry_mode, .i_run_cmd, .i_alarm_reset, .i_stop_key,
        .i_input_power_ok, .i_trip, .i_undervolt, .o_freq_cmd, .o_output_on,
        .o_pl_decel_active, .o_pl_hold, .o_trip_alarm, .o_state);
    pld_bus_model pld_bus_model_inst (.i_clk, .i_resetn, .i_pwr(i_input_power_ok), .i_regen(regen),
        .o_bus(i_bus_voltage), .o_uv(i_undervolt));
    initial begin
        i_clk = 0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic summarize();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Polls once a cycle; a bound that runs out ends the run
    task automatic wst(input logic [2:0] s, input int lim);
        int k;
        k = 0;
        while (o_state !== s && k < lim) begin
            cyc(1);
            k++;
        end
        chk("state", 16'(o_state), 16'(s));
        if (o_state !== s) summarize();
    endtask
    initial begin
        {i_resetn, i_stop_key_enable, i_retry_mode, i_run_cmd} = 4'h0;
        {i_alarm_reset, i_stop_key, i_trip, regen} = 4'h0;
        i_input_power_ok = 1;
        i_pl_decel_enable = `PLD_EN_ENABLE;
        i_bus_trigger_level = 14'h0af0;
        i_bus_overvolt_threshold = 14'h0dac;
        i_pl_decel_time = 19'h00001;
        i_pl_initial_freq_drop = 16'h0064;
        i_max_freq = 16'h0014;
        i_freq_target = 16'h012c;
        cyc(5);
        chk("reset state", 16'(o_state), 16'(`PLD_ST_IDLE));
        i_resetn = 1;
        i_run_cmd = 1;
        wst(`PLD_ST_RUN, 20);
        cyc(2);
        chk("run freq", o_freq_cmd, 16'h012c);
        chk("run output", 16'(o_output_on), 16'h1);
        i_input_power_ok = 0;
        wst(`PLD_ST_STEP, 400);
        cyc(1);
        chk("stepped freq", o_freq_cmd, 16'h00c8);
        repeat (2) begin
            regen = 1;
            wst(`PLD_ST_HOLD, 200);
            chk("hold flag", 16'(o_pl_hold), 16'h1);
            regen = 0;
            wst(`PLD_ST_RAMP, 400);
            chk("hold cleared", 16'(o_pl_hold), 16'h0);
        end
        i_input_power_ok = 1;
        cyc(8);
        chk("decel kept", 16'(o_pl_decel_active), 16'h1);
        chk("output kept", 16'(o_output_on), 16'h1);
        wst(`PLD_ST_IDLE, 400);
        chk("stopped freq", o_freq_cmd, 16'h0000);
        wst(`PLD_ST_RUN, 5);
        i_max_freq = 16'h0001;
        i_input_power_ok = 0;
        wst(`PLD_ST_STEP, 400);
        cyc(401);
        chk("ramp rate", 16'(o_freq_cmd >= 16'h00b3 && o_freq_cmd <= 16'h00b5), 16'h1);
        wst(`PLD_ST_TRIP, 1000);
        chk("uv alarm", 16'(o_trip_alarm), 16'h1);
        i_input_power_ok = 1;
        i_stop_key = 1;
        cyc(10);
        chk("stop key off", 16'(o_state), 16'(`PLD_ST_TRIP));
        chk("alarm kept", 16'(o_trip_alarm), 16'h1);
        i_stop_key = 0;
        i_alarm_reset = 1;
        wst(`PLD_ST_RUN, 20);
        chk("alarm cleared", 16'(o_trip_alarm), 16'h0);
        i_alarm_reset = 0;
        i_pl_decel_enable = `PLD_EN_DISABLE;
        i_bus_trigger_level = 14'h0c00;
        cyc(20);
        chk("off below trigger", 16'(o_state), 16'(`PLD_ST_RUN));
        i_input_power_ok = 0;
        wst(`PLD_ST_COAST, 20);
        cyc(300);
        chk("no decel when off", 16'(o_state), 16'(`PLD_ST_COAST));
        chk("coast alarm", 16'({o_trip_alarm, o_output_on}), 16'h0);
        chk("coast freq", o_freq_cmd, 16'h0000);
        i_input_power_ok = 1;
        wst(`PLD_ST_RUN, 20);
        i_retry_mode = 1;
        i_trip = 1;
        wst(`PLD_ST_TRIP, 20);
        cyc(3);
        i_trip = 0;
        wst(`PLD_ST_RUN, 20);
        chk("retry alarm", 16'(o_trip_alarm), 16'h0);
        i_retry_mode = 0;
        i_stop_key_enable = 1;
        i_stop_key = 1;
        wst(`PLD_ST_IDLE, 20);
        cyc(10);
        chk("stop key held", 16'(o_state), 16'(`PLD_ST_IDLE));
        i_stop_key = 0;
        i_run_cmd = 0;
        cyc(6);
        i_run_cmd = 1;
        wst(`PLD_ST_RUN, 20);
        summarize();
    end
endmodule
